/* hdl/ctm_pkg.sv */
// package: register map, field positions and encodings of the compact timer
package ctm_pkg;
    // register byte addresses
    localparam logic [11:0] CTM_CTRL0_ADDR  = 12'h000;
    localparam logic [11:0] CTM_CTRL1_ADDR  = 12'h004;
    localparam logic [11:0] CTM_CMPA_ADDR   = 12'h008;
    localparam logic [11:0] CTM_COUNT_ADDR  = 12'h00C;
    localparam logic [11:0] CTM_STATUS_ADDR = 12'h010;
    // control 0 fields
    localparam int CTM_C0_RUN_BIT  = 3;
    localparam int CTM_C0_PER_LSB  = 0;
    localparam int CTM_C0_PAU_BIT  = 7;
    // control 1 fields
    localparam int CTM_C1_MODE_LSB = 6;
    localparam int CTM_C1_ACT_LSB  = 4;
    localparam int CTM_C1_INIT_BIT = 3;
    localparam int CTM_C1_POL_BIT  = 2;
    localparam int CTM_C1_CLR_BIT  = 0;
    // reset values
    localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
    localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
    localparam logic [9:0] CTM_CMPA_RST  = 10'h000;
    // operating modes
    localparam logic [1:0] CTM_MODE_CMP  = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM  = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR  = 2'h3;
    // pin actions
    localparam logic [1:0] CTM_ACT_HOLD  = 2'h0;
    localparam logic [1:0] CTM_ACT_LOW   = 2'h1;
    localparam logic [1:0] CTM_ACT_HIGH  = 2'h2;
    localparam logic [1:0] CTM_ACT_TOG   = 2'h3;
    // counter width
    localparam int CTM_CNT_W = 10;
endpackage

/* hdl/ctm_counter.sv */
// 10-bit count-up core with comparator a and period comparator
`timescale 1ns/10ps
module ctm_counter
    import ctm_pkg::*;
#(
    parameter int CNT_W = CTM_CNT_W
) (
    input  wire logic             ref_clk,     // system clock
    input  wire logic             srst,        // sync reset, high
    input  wire logic             run,         // counter on level
    input  wire logic             run_rise,    // counter on rising edge
    input  wire logic             pause,       // hold count
    input  wire logic             clr_sel,     // 0: period match clears
    input  wire logic [2:0]       period,      // period compare value
    input  wire logic [CNT_W-1:0] cmp_a,       // compare value a
    output logic      [CNT_W-1:0] count,       // counter value
    output logic                  match_a,     // high the cycle before count first reaches cmp_a
    output logic                  match_p      // period match pulse
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;

    // count; rising on-bit clears, falling keeps value
    always_comb begin
        cnt_next = cnt_reg;
        if (run_rise) begin
            cnt_next = '0;                              // [RULE10]
        end else if (run && !pause) begin
            if (!clr_sel && period != 3'h0
                && cnt_reg[CNT_W-1:CNT_W-3] == period) begin
                cnt_next = '0;                          // [RULE12]
            end else if (cmp_a != '0 && cnt_reg == cmp_a && clr_sel) begin
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) cnt_reg <= '0;
        else      cnt_reg <= cnt_next;
    end

    assign count = cnt_reg;
    // full-width compare, only while counting and on the first such cycle
    assign match_a = run && !run_rise && (cnt_next == cmp_a)
                     && (cnt_next != cnt_reg);          // [RULE11] [RULE13]
    assign match_p = run && !run_rise && !clr_sel && period != 3'h0
                     && cnt_reg[CNT_W-1:CNT_W-3] == period && !pause;
endmodule // ctm_counter

/* hdl/ctm_timer.sv */
// compact timer top: apb registers, mode select and output pin control
//
// Contract
// RULE1 - mode field: 00 compare output, 10 pwm, 11 timer; 01 undefined
// RULE2 - software should switch timer off before changing the mode
// RULE3 - timer/counter mode never drives the output pin
// RULE4 - compare mode match: 00 hold, 01 low, 10 high, 11 toggle
// RULE5 - pwm: 00 inactive, 01 active, 10 waveform, 11 undefined
// RULE6 - match requesting the initial level leaves the pin unchanged
// RULE7 - on-bit rising returns the pin to its initial level
// RULE8 - software changes pwm pin action only while switched off
// RULE9 - initial-level bit is bit 3; 0 means initial low
// RULE10 - on-bit rising clears counter; falling keeps it
// RULE11 - comparator a compares all ten counter bits
// RULE12 - clear-select 0: period match on top three bits clears counter
// RULE13 - match pin action happens the cycle counter first equals value a
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ctm_timer
    import ctm_pkg::*;
(
    input  wire logic        ref_clk,       // 20 mhz clock
    input  wire logic        srst,          // sync reset, high
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb write
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    output logic             timer_output_pin,    // pin level
    output logic             timer_output_pin_oe_n // low while driving
);
    logic [7:0]  ctrl0_reg, ctrl0_next;
    logic [7:0]  timer_mode_pin_control_reg, tmpc_next;
    logic [9:0]  cmpa_reg, cmpa_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic        pin_reg, pin_next;
    logic        oe_n_reg, oe_n_next;
    logic        run_d_reg;
    logic        pwm_reg, pwm_next;
    logic [9:0]  count;
    logic        match_a, match_p, run, run_rise;
    logic [1:0]  mode_sel, pin_action;
    logic        output_initial_level, counter_on, pol;
    logic        acc, wr, hit;

    assign mode_sel             = timer_mode_pin_control_reg[7:6];
    assign pin_action           = timer_mode_pin_control_reg[5:4];
    assign output_initial_level =
        timer_mode_pin_control_reg[CTM_C1_INIT_BIT];     // [RULE9]
    assign pol        = timer_mode_pin_control_reg[CTM_C1_POL_BIT];
    assign counter_on = ctrl0_reg[CTM_C0_RUN_BIT];
    assign run        = counter_on;
    assign run_rise   = counter_on && !run_d_reg;

    ctm_counter #(.CNT_W(CTM_CNT_W)) u_cnt (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .run      (run),
        .run_rise (run_rise),
        .pause    (ctrl0_reg[CTM_C0_PAU_BIT]),
        .clr_sel  (timer_mode_pin_control_reg[CTM_C1_CLR_BIT]),
        .period   (ctrl0_reg[2:0]),
        .cmp_a    (cmpa_reg),
        .count    (count),
        .match_a  (match_a),
        .match_p  (match_p)
    );

    function automatic logic addr_ok(input logic [11:0] a);
        return a == CTM_CTRL0_ADDR || a == CTM_CTRL1_ADDR ||
               a == CTM_CMPA_ADDR  || a == CTM_COUNT_ADDR ||
               a == CTM_STATUS_ADDR;
    endfunction

    assign acc = psel && penable && !pready_reg;
    assign hit = addr_ok(paddr);
    // the write commits at the edge where the master samples pready high,
    // so a master that aborts before the answer leaves registers untouched
    assign wr  = psel && penable && pready_reg && pwrite && hit;

    // apb slave: one wait state, answer with pready in second access cycle;
    // the mode field is stored as written, software keeps the timer off
    // while changing it (mode 01 then behaves as timer mode: pin released)
    always_comb begin
        ctrl0_next   = ctrl0_reg;
        tmpc_next    = timer_mode_pin_control_reg;
        cmpa_next    = cmpa_reg;
        prdata_next  = prdata_reg;
        pready_next  = acc;
        pslverr_next = acc && !hit;
        if (wr) begin
            case (paddr)
                CTM_CTRL0_ADDR: ctrl0_next = pwdata[7:0];
                CTM_CTRL1_ADDR: tmpc_next  = pwdata[7:0];
                CTM_CMPA_ADDR:  cmpa_next  = pwdata[9:0];
                default: ;
            endcase
        end
        if (acc && !pwrite) begin
            case (paddr)
                CTM_CTRL0_ADDR:  prdata_next = {24'h00_0000, ctrl0_reg};
                CTM_CTRL1_ADDR:  prdata_next =
                    {24'h00_0000, timer_mode_pin_control_reg};
                CTM_CMPA_ADDR:   prdata_next = {22'h00_0000, cmpa_reg};
                CTM_COUNT_ADDR:  prdata_next = {22'h00_0000, count};
                CTM_STATUS_ADDR: prdata_next =
                    {29'h0000_0000, pwm_reg, !oe_n_reg, pin_reg};
                default:         prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // output pin: per mode behaviour
    always_comb begin
        pin_next  = pin_reg;
        oe_n_next = 1'b0;
        pwm_next  = pwm_reg;
        // pwm waveform: active while counter below value a, period match restarts it
        if (!run || run_rise || match_p) pwm_next = 1'b1;
        if (match_a) pwm_next = 1'b0;
        case (mode_sel)                                 // [RULE1]
            CTM_MODE_CMP: begin
                if (run_rise) begin
                    pin_next = output_initial_level;    // [RULE7]
                end else if (match_a) begin             // [RULE13]
                    case (pin_action)                   // [RULE4]
                        CTM_ACT_LOW:  pin_next = 1'b0;
                        CTM_ACT_HIGH: pin_next = 1'b1;
                        CTM_ACT_TOG:  pin_next = !pin_reg;
                        default:      pin_next = pin_reg;
                    endcase
                    // requesting the initial level changes nothing
                    if (pin_action != CTM_ACT_TOG && pin_action != CTM_ACT_HOLD
                        && pin_next == output_initial_level)
                        pin_next = pin_reg;             // [RULE6]
                end
            end
            CTM_MODE_PWM: begin
                case (pin_action)                       // [RULE5]
                    CTM_ACT_HOLD: pin_next = !pol;
                    CTM_ACT_LOW:  pin_next = pol;
                    CTM_ACT_HIGH: pin_next = pwm_next ~^ pol;
                    default:      pin_next = pin_reg;   // undefined: hold
                endcase
            end
            default: begin
                oe_n_next = 1'b1;                       // [RULE3]
                pin_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl0_reg                  <= CTM_CTRL0_RST;
            timer_mode_pin_control_reg <= CTM_CTRL1_RST;
            cmpa_reg                   <= CTM_CMPA_RST;
            prdata_reg                 <= 32'h0000_0000;
            pready_reg                 <= 1'b0;
            pslverr_reg                <= 1'b0;
            pin_reg                    <= 1'b0;
            oe_n_reg                   <= 1'b0;
            run_d_reg                  <= 1'b0;
            pwm_reg                    <= 1'b1;
        end else begin
            ctrl0_reg                  <= ctrl0_next;
            timer_mode_pin_control_reg <= tmpc_next;
            cmpa_reg                   <= cmpa_next;
            prdata_reg                 <= prdata_next;
            pready_reg                 <= pready_next;
            pslverr_reg                <= pslverr_next;
            pin_reg                    <= pin_next;
            oe_n_reg                   <= oe_n_next;
            run_d_reg                  <= counter_on;
            pwm_reg                    <= pwm_next;
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign timer_output_pin      = pin_reg;
    assign timer_output_pin_oe_n = oe_n_reg;
endmodule // ctm_timer

/* test/ctm_timer_properties.sv */
// concurrent checks on the compact timer register port and output pin
`timescale 1ns/10ps
module ctm_timer_properties
    import ctm_pkg::*;
(
    input wire logic        ref_clk,              // clock
    input wire logic        srst,                 // sync reset
    input wire logic        psel,                 // apb select
    input wire logic        penable,              // apb enable
    input wire logic        pwrite,               // apb write
    input wire logic [11:0] paddr,                // apb address
    input wire logic [31:0] pwdata,               // apb write data
    input wire logic [31:0] prdata,               // apb read data
    input wire logic        pready,               // apb ready
    input wire logic        pslverr,              // apb error
    input wire logic        timer_output_pin,     // pin level
    input wire logic        timer_output_pin_oe_n // pin enable, low
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // a control write lands at pready; pin logic follows one edge later
    wire c1_wr = pready && pwrite && paddr == CTM_CTRL1_ADDR;

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not given after one wait state");
    a_no_spurious: assert property (!(psel && penable) |=> !pready)
        else $error("ready without an access");
    a_err_unmapped: assert property (pready && paddr > CTM_STATUS_ADDR
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (pready && paddr == CTM_CTRL1_ADDR
        |-> !pslverr) else $error("mapped access refused");
    a_reset_outs: assert property (disable iff (1'b0) srst |=>
        !pready && !timer_output_pin && !timer_output_pin_oe_n)
        else $error("outputs not cleared by reset");
    a_timer_released: assert property (c1_wr && pwdata[7:6] == CTM_MODE_TMR
        |-> ##2 timer_output_pin_oe_n)
        else $error("pin driven in timer mode");
    a_mode_driven: assert property (c1_wr && (pwdata[7:6] == CTM_MODE_CMP
        || pwdata[7:6] == CTM_MODE_PWM) |-> ##2 !timer_output_pin_oe_n)
        else $error("pin not driven in output mode");
    a_pwm_forced: assert property (c1_wr && pwdata[7:6] == CTM_MODE_PWM
        && !pwdata[5] && pwdata[2]
        |-> ##2 timer_output_pin == $past(pwdata[4], 2))
        else $error("pwm forced level wrong");
endmodule // ctm_timer_properties

bind ctm_timer ctm_timer_properties ctm_timer_properties_i (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe_n(timer_output_pin_oe_n));

/* test/tb.sv */
// self-checking bench for the compact timer mode and pin control
`timescale 1ns/10ps
module tb;
    import ctm_pkg::*;
    logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, rd2;
    logic pready, pslverr, pin, oe_n, err;
    int err_total = 0, cmp_count = 0;

    ctm_timer ctm_timer_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_output_pin(pin), .timer_output_pin_oe_n(oe_n));

    always #25 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20) check(0, 1);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog: the sequence needs far fewer than 20000 cycles
    initial begin
        #(50 * 20000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        logic [1:0] exp;
        idle(6);
        srst <= 0;
        apb(0, CTM_CTRL1_ADDR, 0); check(rd, 32'h0000_0000);
        check({pin, oe_n}, 2'b00);
        apb(0, 12'h020, 0); check({err, rd}, {1'b1, 32'h0000_0000});
        apb(1, CTM_CTRL1_ADDR, 32'h0000_00C0); idle(2);
        check(oe_n, 1);
        apb(1, CTM_CTRL1_ADDR, 32'h0000_0000); idle(2);
        check(oe_n, 0);
        // wide compare value: the top bits must take part in the match
        apb(1, CTM_CMPA_ADDR, 32'h0000_0108);
        apb(1, CTM_CTRL1_ADDR, 32'h0000_0020);
        apb(1, CTM_CTRL0_ADDR, 32'h0000_0008); idle(200);
        check(pin, 0);
        idle(80);
        check(pin, 1);
        // off keeps the count frozen
        apb(1, CTM_CTRL0_ADDR, 0); apb(0, CTM_COUNT_ADDR, 0); rd2 = rd;
        idle(5);
        apb(0, CTM_COUNT_ADDR, 0); check(rd, rd2);
        apb(1, CTM_CMPA_ADDR, 32'h0000_0008);
        // every action with both initial levels; mode is changed only off
        for (int k = 0; k < 8; k++) begin
            exp = (k >> 1 == 0) ? k[1:0] & 1 : (k >> 1 == 1) ? 0 :
                  (k >> 1 == 2) ? 1 : ~k[0];
            apb(1, CTM_CTRL0_ADDR, 0);
            apb(1, CTM_CTRL1_ADDR, {26'h0, k[2:1], k[0], 3'h0});
            apb(1, CTM_CTRL0_ADDR, 32'h0000_0008); idle(2);
            check(pin, k[0]);
            apb(0, CTM_COUNT_ADDR, 0); check(rd < 32'd12, 1);
            idle(20);
            check(pin, exp[0]);
        end
        // pwm forced levels, active high, action changed only while off
        for (int k = 0; k < 2; k++) begin
            apb(1, CTM_CTRL0_ADDR, 0);
            apb(1, CTM_CTRL1_ADDR, {24'h0, 2'b10, 1'b0, k[0], 4'h4});
            apb(1, CTM_CTRL0_ADDR, 32'h0000_0008); idle(3);
            check({pin, oe_n}, {k[0], 1'b0});
        end
        apb(1, CTM_CTRL0_ADDR, 0);
        apb(1, CTM_CTRL1_ADDR, 32'h0000_00E0);
        apb(1, CTM_CTRL0_ADDR, 32'h0000_0008); idle(20);
        check(oe_n, 1);
        tally_and_finish();
    end
endmodule // tb
